// ---- rtl/bert_params.svh ----
`ifndef BERT_PARAMS_SVH
`define BERT_PARAMS_SVH

// register map (byte addresses)
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_BLKLEN 12'h008
`define REG_TX_BITS 12'h010
`define REG_RX_BITS 12'h014
`define REG_RX_ERRS 12'h018
`define REG_TX_ERRS 12'h01C
`define REG_TX_BLKS 12'h020
`define REG_RX_BLKS 12'h024
`define REG_RX_EBLKS 12'h028
`define REG_BER 12'h02C
`define REG_BLER 12'h030
`define REG_EFS 12'h034
`define REG_ES 12'h038
`define REG_SES 12'h03C
`define REG_CSES 12'h040
`define REG_DM 12'h044
`define REG_UAS 12'h048
`define REG_ELAPSED 12'h04C

// ctrl fields
`define CTRL_RUN 0
`define CTRL_INS_ERR 1
`define CTRL_STAT_RST 2
`define CTRL_CONT 3

`define BLKLEN_RESET 32'h0000_0400

// timing
`define CLK_HZ 125000000
`define SEC_NS 1000000000
`define CLK_PERIOD_NS 8
`define SEC_CYCLES (`SEC_NS / `CLK_PERIOD_NS)
`define SECS_PER_MIN 60
`define UAS_RUN 10
// ratio scale: rates reported as parts per 2^24
`define RATE_SHIFT 24

`endif

// ---- rtl/bert_pkg.sv ----
package bert_pkg;
	typedef enum logic [1:0] {
		st_idle,
		st_no_sync,
		st_in_sync
	} test_status_t;

	typedef struct packed {
		logic valid;
		logic data;
		logic expect_bit;
		logic blk_end;
	} rx_bit_t;

	typedef struct packed {
		logic valid;
		logic blk_end;
		logic err_ins;
	} tx_bit_t;
endpackage

// ---- rtl/bert_counter.sv ----
`timescale 1ns/1ps
`default_nettype none
module bert_counter #(
	parameter int W = 32
) (
	input wire logic clk,
	input wire logic clr,
	input wire logic inc,
	output logic [W-1:0] count
);
	logic [W-1:0] count_q;
	// saturates rather than wrapping so long runs never read low
	wire at_max = &count_q;
	always_ff @(posedge clk) begin
		if (clr)
			count_q <= '0;
		else if (inc && !at_max)
			count_q <= count_q + W'(1);
	end
	assign count = count_q;
endmodule
`default_nettype wire

// ---- rtl/bert_ratio.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "bert_params.svh"
// sequential restoring divider: quot = (num << RATE_SHIFT) / den
module bert_ratio #(
	parameter int W = 32
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [W-1:0] num,
	input wire logic [W-1:0] den,
	output logic [W-1:0] quot
);
	localparam int NW = W + `RATE_SHIFT;
	logic [NW-1:0] n_q;
	logic [NW-1:0] q_q;
	logic [NW:0] r_q;
	logic [W-1:0] den_q;
	logic [W-1:0] quot_q;
	logic [$clog2(NW+1)-1:0] i_q;
	wire [NW:0] r_sh = {r_q[NW-1:0], n_q[NW-1]};
	wire ge = r_sh >= {{(NW+1-W){1'b0}}, den_q};
	always_ff @(posedge clk) begin
		if (reset) begin
			i_q <= '0;
			n_q <= '0;
			q_q <= '0;
			r_q <= '0;
			den_q <= '0;
			quot_q <= '0;
		end else if (i_q == '0) begin
			// a restart snapshots inputs; divide by zero reads as zero
			quot_q <= (den_q == '0) ? '0 : q_q[W-1:0];
			n_q <= {num, {`RATE_SHIFT{1'b0}}};
			den_q <= den;
			r_q <= '0;
			q_q <= '0;
			i_q <= ($clog2(NW+1))'(NW);
		end else begin
			r_q <= ge ? r_sh - {{(NW+1-W){1'b0}}, den_q} : r_sh;
			q_q <= {q_q[NW-2:0], ge};
			n_q <= {n_q[NW-2:0], 1'b0};
			i_q <= i_q - 1'b1;
		end
	end
	assign quot = quot_q;
endmodule
`default_nettype wire

// ---- rtl/bert_stats.sv ----
// What this block does
// RQ1 - status idle, not synced or synced
// RQ2 - count every transmitted bit
// RQ3 - count every received bit
// RQ4 - count received bits mismatching expected pattern
// RQ5 - count inserted errors, insert only on command
// RQ6 - receive bit error rate is errors over bits
// RQ7 - receive totals accumulate, restart on stats reset
// RQ8 - count transmitted complete blocks
// RQ9 - count received complete blocks
// RQ10 - count blocks holding any bit error once
// RQ11 - receive block error rate since last reset
// RQ12 - error-free available seconds counted each second
// RQ13 - errored seconds counted each second
// RQ14 - severely errored second above 1e-3 rate
// RQ15 - track consecutive severely errored seconds
// RQ16 - degraded minute from 60 clean seconds above 1e-6
// RQ17 - unavailable once over 10 consecutive severe seconds
// RQ18 - stats reset clears all, continuous test resumes
// RQ19 - elapsed seconds counter while test runs
// RQ20 - one-second tick from system clock
`timescale 1ns/1ps
`default_nettype none
`include "bert_params.svh"
module bert_stats #(
	parameter int CW = 32,
	parameter int SEC_CYCLES = `SEC_CYCLES
) (
	// system
	input wire logic clk,
	input wire logic reset,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// line side
	input wire bert_pkg::tx_bit_t tx_in,
	input wire bert_pkg::rx_bit_t rx_in,
	input wire logic line_lock,
	output logic tx_err_req,
	output logic test_running,
	output bert_pkg::test_status_t status
);
	// control registers
	logic run_q, cont_q, ins_pend_q, clr_q;
	logic [31:0] blklen_q;
	wire acc = psel && penable;
	wire wr = acc && pwrite;
	wire wr_ctrl = wr && paddr == `REG_CTRL;
	wire wr_blk = wr && paddr == `REG_BLKLEN;
	wire stat_rst = wr_ctrl && pwdata[`CTRL_STAT_RST]; // RQ18
	wire ins_cmd = wr_ctrl && pwdata[`CTRL_INS_ERR];
	// continuous mode: a stats reset must not stop a running test
	wire keep_run = stat_rst && cont_q && run_q;
	always_ff @(posedge clk) begin
		if (reset) begin
			run_q <= 1'b0;
			cont_q <= 1'b0;
			blklen_q <= `BLKLEN_RESET;
		end else begin
			if (wr_ctrl) run_q <= pwdata[`CTRL_RUN] || keep_run; // RQ18
			if (wr_ctrl) cont_q <= pwdata[`CTRL_CONT];
			if (wr_blk) blklen_q <= pwdata;
		end
	end
	// clear pulse one cycle after the write; run stays set in
	// continuous mode so testing resumes by itself
	always_ff @(posedge clk) begin
		if (reset) clr_q <= 1'b1;
		else clr_q <= stat_rst; // RQ18 RQ7
	end
	wire clr = clr_q;
	// single error insertion: held until tx consumes it
	always_ff @(posedge clk) begin
		if (reset) ins_pend_q <= 1'b0;
		else if (ins_cmd) ins_pend_q <= 1'b1; // RQ5
		else if (tx_in.valid && tx_in.err_ins) ins_pend_q <= 1'b0;
	end
	// status
	wire bert_pkg::test_status_t st_d = !run_q ? bert_pkg::st_idle :
		line_lock ? bert_pkg::st_in_sync : bert_pkg::st_no_sync;
	always_ff @(posedge clk) begin
		if (reset) begin
			status <= bert_pkg::st_idle;
			test_running <= 1'b0;
			tx_err_req <= 1'b0;
		end else begin
			status <= st_d; // RQ1
			test_running <= run_q;
			tx_err_req <= ins_pend_q && !(tx_in.valid && tx_in.err_ins);
		end
	end
	// bit and block event strobes
	wire tx_v = run_q && tx_in.valid;
	wire rx_v = run_q && rx_in.valid;
	wire rx_mis = rx_v && (rx_in.data != rx_in.expect_bit); // RQ4
	logic blk_err_q;
	always_ff @(posedge clk) begin
		if (reset || clr) blk_err_q <= 1'b0;
		else if (rx_v && rx_in.blk_end) blk_err_q <= 1'b0;
		else if (rx_mis) blk_err_q <= 1'b1;
	end
	wire rx_blk = rx_v && rx_in.blk_end; // RQ9
	wire rx_eblk = rx_blk && (blk_err_q || rx_mis); // RQ10
	// one-second tick
	logic [31:0] div_q;
	logic tick;
	always_ff @(posedge clk) begin
		if (reset || !run_q || clr) div_q <= '0;
		else if (div_q == 32'(SEC_CYCLES - 1)) div_q <= '0;
		else div_q <= div_q + 32'h0000_0001;
	end
	assign tick = run_q && div_q == 32'(SEC_CYCLES - 1); // RQ20
	// per-second error and bit tallies
	logic [31:0] sec_err_q, sec_bits_q;
	always_ff @(posedge clk) begin
		if (reset || clr) begin
			sec_err_q <= '0;
			sec_bits_q <= '0;
		end else if (tick) begin
			// the tick cycle's bit opens the next second, not lost
			sec_err_q <= 32'(rx_mis);
			sec_bits_q <= 32'(rx_v);
		end else begin
			if (rx_mis) sec_err_q <= sec_err_q + 32'h0000_0001;
			if (rx_v) sec_bits_q <= sec_bits_q + 32'h0000_0001;
		end
	end
	// severe when err/bits > 1e-3, i.e. err*1000 > bits
	wire [41:0] err_k = 42'(sec_err_q) * 42'd1000;
	wire sev = err_k > 42'(sec_bits_q); // RQ14
	wire errd = sec_err_q != '0;
	// consecutive severe run and availability
	logic [31:0] cses_run_q;
	logic unavail_q;
	wire [31:0] cses_next = sev ? cses_run_q + 32'h0000_0001 : '0;
	always_ff @(posedge clk) begin
		if (reset || clr) begin
			cses_run_q <= '0;
			unavail_q <= 1'b0;
		end else if (tick) begin
			cses_run_q <= cses_next; // RQ15
			if (cses_next > 32'(`UAS_RUN)) unavail_q <= 1'b1; // RQ17
			else if (!sev) unavail_q <= 1'b0;
		end
	end
	wire avail = !(unavail_q || cses_next > 32'(`UAS_RUN));
	// degraded minute accumulation over clean available seconds
	logic [5:0] min_sec_q;
	logic [31:0] min_err_q, min_bits_q;
	wire min_take = tick && avail && !sev;
	wire [31:0] me = min_err_q + sec_err_q;
	wire [31:0] mb = min_bits_q + sec_bits_q;
	wire min_done = min_take && min_sec_q == 6'(`SECS_PER_MIN - 1);
	// worse than 1e-6: err*1e6 > bits
	wire [51:0] me_m = 52'(me) * 52'd1000000;
	wire degraded = min_done && (me_m > 52'(mb)); // RQ16
	always_ff @(posedge clk) begin
		if (reset || clr || min_done) begin
			min_sec_q <= '0;
			min_err_q <= '0;
			min_bits_q <= '0;
		end else if (min_take) begin
			min_sec_q <= min_sec_q + 6'd1;
			min_err_q <= me;
			min_bits_q <= mb;
		end
	end
	// counters
	localparam int NC = 14;
	logic [NC-1:0] inc;
	logic [CW-1:0] cnt [NC];
	assign inc[0] = tx_v; // RQ2
	assign inc[1] = rx_v; // RQ3
	assign inc[2] = rx_mis; // RQ4
	assign inc[3] = tx_v && tx_in.err_ins; // RQ5
	assign inc[4] = tx_v && tx_in.blk_end; // RQ8
	assign inc[5] = rx_blk; // RQ9
	assign inc[6] = rx_eblk; // RQ10
	assign inc[7] = tick && avail && !errd; // RQ12
	assign inc[8] = tick && errd; // RQ13
	assign inc[9] = tick && avail && sev; // RQ14
	assign inc[10] = tick && sev; // RQ15
	assign inc[11] = degraded; // RQ16
	assign inc[12] = tick && !avail; // RQ17
	assign inc[13] = tick; // RQ19
	genvar g;
	generate
		for (g = 0; g < NC; g++) begin : g_cnt
			bert_counter #(.W(CW)) u_cnt (
				.clk(clk),
				.clr(reset || clr), // RQ18 RQ7
				.inc(inc[g]),
				.count(cnt[g])
			);
		end
	endgenerate
	// rates
	logic [CW-1:0] ber, bler;
	bert_ratio #(.W(CW)) u_ber (
		.clk(clk),
		.reset(reset || clr),
		.num(cnt[2]),
		.den(cnt[1]),
		.quot(ber) // RQ6
	);
	bert_ratio #(.W(CW)) u_bler (
		.clk(clk),
		.reset(reset || clr),
		.num(cnt[6]),
		.den(cnt[5]),
		.quot(bler) // RQ11
	);
	// read selection: one hit per word, and-or so unmapped reads zero
	wire hit_ctrl = paddr == `REG_CTRL;
	wire hit_status = paddr == `REG_STATUS;
	wire hit_blklen = paddr == `REG_BLKLEN;
	wire hit_tx_bits = paddr == `REG_TX_BITS;
	wire hit_rx_bits = paddr == `REG_RX_BITS;
	wire hit_rx_errs = paddr == `REG_RX_ERRS;
	wire hit_tx_errs = paddr == `REG_TX_ERRS;
	wire hit_tx_blks = paddr == `REG_TX_BLKS;
	wire hit_rx_blks = paddr == `REG_RX_BLKS;
	wire hit_rx_eblks = paddr == `REG_RX_EBLKS;
	wire hit_ber = paddr == `REG_BER;
	wire hit_bler = paddr == `REG_BLER;
	wire hit_efs = paddr == `REG_EFS;
	wire hit_es = paddr == `REG_ES;
	wire hit_ses = paddr == `REG_SES;
	wire hit_cses = paddr == `REG_CSES;
	wire hit_dm = paddr == `REG_DM;
	wire hit_uas = paddr == `REG_UAS;
	wire hit_elapsed = paddr == `REG_ELAPSED;
	wire [31:0] ctrl_rd = {28'h000_0000, cont_q, 1'b0, ins_pend_q, run_q};
	wire [31:0] status_rd = {29'h0000_0000, unavail_q, status};
	wire [31:0] rd = ({32{hit_ctrl}} & ctrl_rd) |
		({32{hit_status}} & status_rd) |
		({32{hit_blklen}} & blklen_q) |
		({32{hit_tx_bits}} & 32'(cnt[0])) |
		({32{hit_rx_bits}} & 32'(cnt[1])) |
		({32{hit_rx_errs}} & 32'(cnt[2])) |
		({32{hit_tx_errs}} & 32'(cnt[3])) |
		({32{hit_tx_blks}} & 32'(cnt[4])) |
		({32{hit_rx_blks}} & 32'(cnt[5])) |
		({32{hit_rx_eblks}} & 32'(cnt[6])) |
		({32{hit_ber}} & 32'(ber)) |
		({32{hit_bler}} & 32'(bler)) |
		({32{hit_efs}} & 32'(cnt[7])) |
		({32{hit_es}} & 32'(cnt[8])) |
		({32{hit_ses}} & 32'(cnt[9])) |
		({32{hit_cses}} & 32'(cnt[10])) |
		({32{hit_dm}} & 32'(cnt[11])) |
		({32{hit_uas}} & 32'(cnt[12])) |
		({32{hit_elapsed}} & 32'(cnt[13]));
	wire mapped = hit_ctrl || hit_status || hit_blklen || hit_tx_bits ||
		hit_rx_bits || hit_rx_errs || hit_tx_errs || hit_tx_blks ||
		hit_rx_blks || hit_rx_eblks || hit_ber || hit_bler || hit_efs ||
		hit_es || hit_ses || hit_cses || hit_dm || hit_uas || hit_elapsed;
	// zero-wait slave: pready registered, raised in the access cycle
	wire setup = psel && !penable;
	always_ff @(posedge clk) begin
		if (reset) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end else begin
			pready <= setup;
			pslverr <= setup && !mapped;
			// writes read back zero so a refused write shows no stale data
			if (setup) prdata <= pwrite ? 32'h0000_0000 : rd;
		end
	end
endmodule
`default_nettype wire

// ---- sim/bert_remote.sv ----
`timescale 1ns/1ps
`default_nettype none
module bert_remote (
	// system
	input wire logic clk,
	// bench knobs
	input wire logic en,
	input wire logic err,
	// device side
	input wire logic tx_err_req,
	output bert_pkg::tx_bit_t tx_in,
	output bert_pkg::rx_bit_t rx_in,
	output logic line_lock
);
	logic [15:0] n_q = 16'h0000;
	logic t_q = 1'b0;
	wire last = n_q[2:0] == 3'b111;
	wire ins = en && tx_err_req;
	wire pat = n_q[1];
	// loopback: an inserted error comes back flipped
	wire rx_d = en ? (pat ^ err ^ ins) : t_q;
	always_ff @(posedge clk) begin
		t_q <= ~t_q;
		if (en) begin
			n_q <= n_q + 16'h0001;
		end
	end
	assign tx_in = '{valid: en, blk_end: en && last, err_ins: ins};
	assign rx_in = '{valid: en, data: rx_d, expect_bit: pat,
		blk_end: en && last};
	assign line_lock = en;
endmodule
`default_nettype wire

// ---- sim/bert_stats_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "bert_params.svh"
module bert_stats_chk (
	// system
	input wire logic clk,
	input wire logic reset,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// line
	input wire bert_pkg::tx_bit_t tx_in,
	input wire bert_pkg::rx_bit_t rx_in,
	input wire logic line_lock,
	input wire logic tx_err_req,
	input wire logic test_running,
	input wire bert_pkg::test_status_t status
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	wire ctrl_wr = psel && penable && pready && pwrite &&
		paddr == `REG_CTRL;
	wire ins_cmd = ctrl_wr && pwdata[`CTRL_INS_ERR];
	a_ready_after_setup: assert property (psel && !penable |=> pready)
		else $error("pready missing after setup");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready held too long");
	a_slverr_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_slverr_zero: assert property (pslverr |-> prdata == 32'h0000_0000)
		else $error("refused read returned data");
	a_ins_cause: assert property ($rose(tx_err_req) |-> $past(ins_cmd, 2))
		else $error("error request without command");
	a_ins_clear: assert property (tx_err_req && tx_in.valid &&
		tx_in.err_ins |=> !tx_err_req)
		else $error("error request not consumed");
	a_status_idle: assert property ((!test_running)[*3] |->
		status == bert_pkg::st_idle)
		else $error("status not idle when stopped");
	a_status_nosync: assert property ((test_running && !line_lock)[*3]
		|-> status == bert_pkg::st_no_sync)
		else $error("status not no-sync");
	a_status_sync: assert property ((test_running && line_lock)[*3] |->
		status == bert_pkg::st_in_sync)
		else $error("status not in-sync");
	a_run_follow: assert property (ctrl_wr && pwdata[`CTRL_RUN] |->
		##[1:2] test_running)
		else $error("run bit not followed");
	c_refused: cover property (pslverr);
	c_insert: cover property ($rose(tx_err_req));
	c_sync: cover property (status == bert_pkg::st_in_sync);
endmodule
bind bert_stats bert_stats_chk bert_stats_chk_inst (.clk(clk),
	.reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .tx_in(tx_in), .rx_in(rx_in),
	.line_lock(line_lock), .tx_err_req(tx_err_req),
	.test_running(test_running), .status(status));
`default_nettype wire

// ---- sim/bert_stats_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "bert_params.svh"
module bert_stats_tb;
	logic clk, reset, psel, penable, pwrite, en, err, perr;
	logic [11:0] paddr;
	logic [31:0] pwdata, rd;
	wire logic [31:0] prdata;
	wire logic pready, pslverr, line_lock, tx_err_req, test_running;
	wire bert_pkg::tx_bit_t tx_in;
	wire bert_pkg::rx_bit_t rx_in;
	wire bert_pkg::test_status_t status;
	int mismatches = 0;
	int comparisons = 0;
	int i;
	bert_stats #(.SEC_CYCLES(100)) bert_stats_inst (.clk(clk),
		.reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .tx_in(tx_in), .rx_in(rx_in),
		.line_lock(line_lock), .tx_err_req(tx_err_req),
		.test_running(test_running), .status(status));
	bert_remote bert_remote_inst (.clk(clk), .en(en), .err(err),
		.tx_err_req(tx_err_req), .tx_in(tx_in), .rx_in(rx_in),
		.line_lock(line_lock));
	task summarize;
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task chk(input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			mismatches++;
			$display("Error t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		for (k = 0; k < 20; k++) begin
			@(posedge clk);
			if (pready === 1'b1) break;
		end
		rd = prdata;
		perr = pslverr;
		if (k == 20) begin
			mismatches++;
			summarize();
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task rdc(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		chk(rd, e);
	endtask
	task rng(input logic [11:0] a, input int lo, input int hi);
		apb(1'b0, a, 32'h0000_0000);
		chk(rd >= lo && rd <= hi, 32'h0000_0001);
	endtask
	// one bit per cycle; errors on bits e0..e1
	task burst(input int n, input int e0, input int e1);
		for (i = 0; i < n; i++) begin
			en <= 1'b1;
			err <= i >= e0 && i <= e1;
			@(posedge clk);
		end
		en <= 1'b0;
		err <= 1'b0;
	endtask
	initial begin
		clk = 0;
		forever #4 clk = ~clk;
	end
	initial begin
		{reset, psel, penable, pwrite, en, err} = 6'b100000;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		repeat (5) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		rdc(`REG_STATUS, 32'h0000_0000);
		rdc(`REG_RX_BITS, 32'h0000_0000);
		rdc(`REG_BLKLEN, `BLKLEN_RESET);
		rdc(12'h0FC, 32'h0000_0000);
		chk(perr, 1'b1);
		apb(1'b1, `REG_CTRL, 32'h0000_0001);
		@(posedge clk);
		chk(test_running, 1'b1);
		burst(40, 99, 0);
		rdc(`REG_TX_BITS, 32'h0000_0028);
		rdc(`REG_RX_BITS, 32'h0000_0028);
		rdc(`REG_TX_BLKS, 32'h0000_0005);
		rdc(`REG_RX_BLKS, 32'h0000_0005);
		rdc(`REG_RX_ERRS, 32'h0000_0000);
		rdc(`REG_STATUS, 32'h0000_0001);
		apb(1'b1, `REG_CTRL, 32'h0000_0005);
		rdc(`REG_RX_BITS, 32'h0000_0000);
		rdc(`REG_TX_BLKS, 32'h0000_0000);
		burst(16, 1, 3);
		rdc(`REG_RX_ERRS, 32'h0000_0003);
		rdc(`REG_RX_EBLKS, 32'h0000_0001);
		rdc(`REG_RX_BLKS, 32'h0000_0002);
		rdc(`REG_TX_ERRS, 32'h0000_0000);
		repeat (130) @(posedge clk);
		rdc(`REG_BER, 32'h0030_0000);
		rdc(`REG_BLER, 32'h0080_0000);
		chk(tx_err_req, 1'b0);
		apb(1'b1, `REG_CTRL, 32'h0000_0003);
		for (i = 0; i < 10 && tx_err_req !== 1'b1; i++) @(posedge clk);
		chk(i < 10, 1'b1);
		if (i >= 10) summarize();
		burst(8, 99, 0);
		chk(tx_err_req, 1'b0);
		rdc(`REG_TX_ERRS, 32'h0000_0001);
		rdc(`REG_RX_ERRS, 32'h0000_0004);
		rdc(`REG_TX_BITS, 32'h0000_0018);
		apb(1'b1, `REG_CTRL, 32'h0000_0009);
		apb(1'b1, `REG_CTRL, 32'h0000_0004);
		rdc(`REG_CTRL, 32'h0000_0001);
		rdc(`REG_TX_BITS, 32'h0000_0000);
		apb(1'b1, `REG_CTRL, 32'h0000_0005);
		en <= 1'b1;
		repeat (300) @(posedge clk);
		chk(status, bert_pkg::st_in_sync);
		rdc(`REG_ES, 32'h0000_0000);
		rng(`REG_EFS, 2, 4);
		rng(`REG_ELAPSED, 2, 4);
		err <= 1'b1;
		repeat (1300) @(posedge clk);
		rng(`REG_ES, 12, 20);
		rng(`REG_SES, 10, 20);
		rng(`REG_CSES, 10, 20);
		rng(`REG_UAS, 1, 10);
		rdc(`REG_DM, 32'h0000_0000);
		apb(1'b0, `REG_STATUS, 32'h0000_0000);
		chk(rd[2], 1'b1);
		en <= 1'b0;
		err <= 1'b0;
		summarize();
	end
endmodule
`default_nettype wire
